// ==== design/bru_pkg.sv ====
// Purpose: Shared constants and types for the byte rotate unit.
// Assumes: Eight-bit data memory operand and one carry flag.
// Notes:   Opcode encodings are local to this unit.
package bru_pkg;
  localparam int DATA_W   = 8;
  localparam int MSB_POS  = 7;
  localparam int LSB_POS  = 0;
  localparam int OP_W     = 3;
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    BRU_OP_ROTATE_LEFT_TO_ACC       = 3'h0,
    BRU_OP_ROTATE_LEFT_CARRY_MEM    = 3'h1,
    BRU_OP_ROTATE_LEFT_CARRY_TO_ACC = 3'h2,
    BRU_OP_ROTATE_RIGHT_MEM         = 3'h3,
    BRU_OP_ROTATE_RIGHT_TO_ACC      = 3'h4,
    BRU_OP_ROTATE_RIGHT_CARRY_MEM   = 3'h5
  } bru_op_t;
endpackage : bru_pkg

// ==== design/bru_rotate.sv ====
// Purpose: Byte rotate datapath: six one-bit rotates on a data memory operand.
// Assumes: Operand and carry are valid in the cycle op_valid is high.
// Notes:   Results appear one cycle later, registered, with a one-cycle write strobe.
// How it works
// RQ1: Left rotate to accumulator, bit 7 into bit 0, no flag change.
// RQ2: Left rotate memory through carry; bit 7 to carry, carry to bit 0.
// RQ3: Left rotate through carry into accumulator; bit 7 to carry, carry to bit 0.
// RQ4: Right rotate memory, bit 0 into bit 7, no flag change.
// RQ5: Right rotate to accumulator, bit 0 into bit 7, no flag change.
// RQ6: Right rotate memory through carry; bit 0 to carry, carry to bit 7.
// RQ7: Accumulator variants never issue a memory write.
// RQ8: Carry and destination update together, from operands sampled before change.
`timescale 1ns/1ps
module bru_rotate (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Instruction request
  input  wire logic                   op_valid,
  input  wire bru_pkg::bru_op_t       op_code,
  input  wire logic [bru_pkg::DATA_W-1:0] mem_rdata,
  input  wire logic                   carry_in,
  // Write-back
  output logic [bru_pkg::DATA_W-1:0]  mem_wdata,
  output logic                        mem_we,
  output logic [bru_pkg::DATA_W-1:0]  working_accumulator,
  output logic                        acc_we,
  output logic                        carry_out,
  output logic                        carry_we
);
  import bru_pkg::*;

  function automatic logic [DATA_W-1:0] rot_left(input logic [DATA_W-1:0] v, input logic b);
    rot_left = {v[MSB_POS-1:LSB_POS], b};
  endfunction : rot_left

  function automatic logic [DATA_W-1:0] rot_right(input logic [DATA_W-1:0] v, input logic b);
    rot_right = {b, v[MSB_POS:LSB_POS+1]};
  endfunction : rot_right

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the result and its destination.
  wire logic               is_left     = (op_code == BRU_OP_ROTATE_LEFT_TO_ACC) ||
                                         (op_code == BRU_OP_ROTATE_LEFT_CARRY_MEM) ||
                                         (op_code == BRU_OP_ROTATE_LEFT_CARRY_TO_ACC);
  wire logic               thru_carry  = (op_code == BRU_OP_ROTATE_LEFT_CARRY_MEM) ||
                                         (op_code == BRU_OP_ROTATE_LEFT_CARRY_TO_ACC) ||
                                         (op_code == BRU_OP_ROTATE_RIGHT_CARRY_MEM);
  wire logic               to_mem      = (op_code == BRU_OP_ROTATE_LEFT_CARRY_MEM) ||
                                         (op_code == BRU_OP_ROTATE_RIGHT_MEM) ||
                                         (op_code == BRU_OP_ROTATE_RIGHT_CARRY_MEM);
  wire logic               known_op    = (op_code <= BRU_OP_ROTATE_RIGHT_CARRY_MEM);
  // Plain rotates wrap the end bit; through-carry rotates feed the old carry.
  wire logic               left_in     = thru_carry ? carry_in : mem_rdata[MSB_POS]; // RQ1 RQ2 RQ3
  wire logic               right_in    = thru_carry ? carry_in : mem_rdata[LSB_POS]; // RQ4 RQ5 RQ6
  wire logic [DATA_W-1:0]  next_result = is_left ? rot_left(mem_rdata, left_in)
                                                 : rot_right(mem_rdata, right_in);
  wire logic               next_carry  = is_left ? mem_rdata[MSB_POS] : mem_rdata[LSB_POS];
  wire logic               go          = op_valid && known_op;

  ////////////////////////////////////////////////////////////////////////////
  // Write-back: every strobe comes from the same edge so carry and data move together.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_we   <= 1'b0;
      acc_we   <= 1'b0;
      carry_we <= 1'b0;
    end else begin
      mem_we   <= go && to_mem;       // RQ7
      acc_we   <= go && !to_mem;      // RQ1 RQ3 RQ5
      carry_we <= go && thru_carry;   // RQ8
    end
  end

  // Data registers hold their value between instructions to keep outputs steady.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_wdata           <= DATA_RESET;
      working_accumulator <= ACC_RESET;
      carry_out           <= 1'b0;
    end else if (go) begin
      if (to_mem)
        mem_wdata <= next_result;           // RQ2 RQ4 RQ6
      else
        working_accumulator <= next_result; // RQ1 RQ3 RQ5
      if (thru_carry)
        carry_out <= next_carry;            // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_req(bru_op_t op);
    op_valid && op_code == op;
  endsequence

  chk_left_acc_value: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    s_req(BRU_OP_ROTATE_LEFT_TO_ACC) |=> acc_we && !carry_we &&
      working_accumulator == {$past(mem_rdata[MSB_POS-1:LSB_POS]), $past(mem_rdata[MSB_POS])})
    else $error("left rotate to accumulator wrong");

  chk_left_carry_mem: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    s_req(BRU_OP_ROTATE_LEFT_CARRY_MEM) |=> mem_we && carry_we &&
      mem_wdata == {$past(mem_rdata[MSB_POS-1:LSB_POS]), $past(carry_in)} &&
      carry_out == $past(mem_rdata[MSB_POS]))
    else $error("left rotate through carry to memory wrong");

  chk_left_carry_acc: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    s_req(BRU_OP_ROTATE_LEFT_CARRY_TO_ACC) |=> acc_we && carry_we &&
      working_accumulator == {$past(mem_rdata[MSB_POS-1:LSB_POS]), $past(carry_in)} &&
      carry_out == $past(mem_rdata[MSB_POS]))
    else $error("left rotate through carry to accumulator wrong");

  chk_right_mem_value: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    s_req(BRU_OP_ROTATE_RIGHT_MEM) |=> mem_we && !carry_we &&
      mem_wdata == {$past(mem_rdata[LSB_POS]), $past(mem_rdata[MSB_POS:LSB_POS+1])})
    else $error("right rotate to memory wrong");

  chk_right_acc_value: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    s_req(BRU_OP_ROTATE_RIGHT_TO_ACC) |=> acc_we && !carry_we &&
      working_accumulator == {$past(mem_rdata[LSB_POS]), $past(mem_rdata[MSB_POS:LSB_POS+1])})
    else $error("right rotate to accumulator wrong");

  chk_right_carry_mem: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    s_req(BRU_OP_ROTATE_RIGHT_CARRY_MEM) |=> mem_we && carry_we &&
      mem_wdata == {$past(carry_in), $past(mem_rdata[MSB_POS:LSB_POS+1])} &&
      carry_out == $past(mem_rdata[LSB_POS]))
    else $error("right rotate through carry to memory wrong");

  chk_acc_no_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    !(mem_we && acc_we))
    else $error("memory written by accumulator variant");

  chk_carry_with_dest: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    carry_we |-> (mem_we || acc_we) && $past(op_valid))
    else $error("carry update not paired with destination write");

  chk_strobe_single: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    !op_valid |=> !mem_we && !acc_we && !carry_we)
    else $error("write strobe without request");

  ////////////////////////////////////////////////////////////////////////////
  // Hold and quiet checks: a result register moves only for its own destination.
  // The request groups are spelled out from the opcodes, not from the decode wires,
  // so that a fault in the decode cannot hide itself.
  sequence s_mem_req;
    op_valid && (op_code == BRU_OP_ROTATE_LEFT_CARRY_MEM ||
                 op_code == BRU_OP_ROTATE_RIGHT_MEM ||
                 op_code == BRU_OP_ROTATE_RIGHT_CARRY_MEM);
  endsequence

  sequence s_acc_req;
    op_valid && (op_code == BRU_OP_ROTATE_LEFT_TO_ACC ||
                 op_code == BRU_OP_ROTATE_LEFT_CARRY_TO_ACC ||
                 op_code == BRU_OP_ROTATE_RIGHT_TO_ACC);
  endsequence

  sequence s_plain_req;
    op_valid && (op_code == BRU_OP_ROTATE_LEFT_TO_ACC ||
                 op_code == BRU_OP_ROTATE_RIGHT_MEM ||
                 op_code == BRU_OP_ROTATE_RIGHT_TO_ACC);
  endsequence

  sequence s_thru_req;
    op_valid && (op_code == BRU_OP_ROTATE_LEFT_CARRY_MEM ||
                 op_code == BRU_OP_ROTATE_LEFT_CARRY_TO_ACC ||
                 op_code == BRU_OP_ROTATE_RIGHT_CARRY_MEM);
  endsequence

  sequence s_bad_req;
    op_valid && (op_code > BRU_OP_ROTATE_RIGHT_CARRY_MEM);
  endsequence

  chk_mem_dest_one: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    s_mem_req |=> mem_we && !acc_we)
    else $error("memory variant did not write memory alone");

  chk_acc_dest_one: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    s_acc_req |=> acc_we && !mem_we)
    else $error("accumulator variant did not load accumulator alone");

  chk_thru_flag: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    s_thru_req |=> carry_we)
    else $error("through-carry variant did not update carry");

  chk_acc_held_mem: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    s_mem_req |=> $stable(working_accumulator))
    else $error("accumulator changed by memory variant");

  chk_mem_held_acc: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    s_acc_req |=> $stable(mem_wdata))
    else $error("memory data changed by accumulator variant");

  chk_plain_no_flag: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    s_plain_req |=> !carry_we && $stable(carry_out))
    else $error("plain rotate touched the carry");

  chk_bad_op_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    s_bad_req |=> !mem_we && !acc_we && !carry_we)
    else $error("unused opcode raised a write strobe");

  chk_idle_hold: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    !op_valid |=> $stable(working_accumulator) && $stable(mem_wdata) &&
      $stable(carry_out))
    else $error("result register moved without a request");

  // Reset checks carry no disable, so the reset cycles themselves are watched.
  chk_reset_strobes: assert property (@(posedge sys_clk) // RQ7
    rst |=> !mem_we && !acc_we && !carry_we)
    else $error("write strobe after reset");

  chk_reset_values: assert property (@(posedge sys_clk) // RQ8
    rst |=> working_accumulator == ACC_RESET && mem_wdata == DATA_RESET && !carry_out)
    else $error("result registers not cleared by reset");
endmodule : bru_rotate

// ==== sim/bru_mem_model.sv ====
// Purpose: Memory byte and carry flag on the far side of the unit.
// Assumes: One operand location.
// Notes:   The bench presets the state; strobes update it.
`timescale 1ns/1ps
module bru_mem_model (
  // Clock and preset
  input  wire logic       sys_clk,
  input  wire logic       preset,
  input  wire logic [7:0] preset_byte,
  input  wire logic       preset_carry,
  // Write-back
  input  wire logic [7:0] mem_wdata,
  input  wire logic       mem_we,
  input  wire logic       carry_out,
  input  wire logic       carry_we,
  // Operand
  output logic      [7:0] mem_rdata,
  output logic            carry_in
);
  always_ff @(posedge sys_clk) begin
    if (preset) begin
      mem_rdata <= preset_byte;
      carry_in  <= preset_carry;
    end else begin
      if (mem_we) mem_rdata <= mem_wdata;
      if (carry_we) carry_in <= carry_out;
    end
  end
endmodule : bru_mem_model

// ==== sim/test_bru_rotate.sv ====
// Purpose: Self-checking bench for the rotate unit.
// Assumes: Results one cycle after the request.
// Notes:   Memory is read back to prove the written byte, or the untouched byte for accumulator and unused ops.
`timescale 1ns/1ps
module test_bru_rotate;
  import bru_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, pre = 1'b1, pc = 1'b0;
  logic [7:0] pb = 8'h00, mem_rdata, mem_wdata, acc;
  logic       carry_in, mem_we, acc_we, carry_out, carry_we;
  bru_op_t    op_code = BRU_OP_ROTATE_LEFT_TO_ACC;
  int         fail_count = 0, num_checks = 0;
  bru_rotate dut_u (.sys_clk, .rst, .op_valid, .op_code, .mem_rdata, .carry_in, .mem_wdata,
    .mem_we, .working_accumulator(acc), .acc_we, .carry_out, .carry_we);
  bru_mem_model mod_u (.sys_clk, .preset(pre), .preset_byte(pb), .preset_carry(pc),
    .mem_wdata, .mem_we, .carry_out, .carry_we, .mem_rdata, .carry_in);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Presets operand and carry, issues one op, judges the strobes, the written result for used opcodes, and the carry for through-carry ops.
  task automatic do_op(input logic [2:0] op, input logic [7:0] b, input logic c);
    logic [7:0] res;
    logic       nc, to_mem, thru;
    nc = c;
    case (op)
      3'h0: res = {b[6:0], b[7]};
      3'h1, 3'h2: {nc, res} = {b, c};
      3'h3, 3'h4: res = {b[0], b[7:1]};
      default: {res, nc} = {c, b};
    endcase
    to_mem = (op == 3'h1) || (op == 3'h3) || (op == 3'h5);
    thru = (op == 3'h1) || (op == 3'h2) || (op == 3'h5);
    @(posedge sys_clk);
    pre <= 1'b1; pb <= b; pc <= c;
    @(posedge sys_clk);
    pre <= 1'b0; op_valid <= 1'b1; op_code <= bru_op_t'(op);
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    if (op > 3'h5) begin
      res = 8'h00;
      nc  = c;
    end
    check("mem_we", mem_we, to_mem);
    check("acc_we", acc_we, !to_mem && op < 3'h6);
    check("carry_we", carry_we, thru);
    if (op < 3'h6) check("result", to_mem ? mem_wdata : acc, res);
    if (thru) check("carry", carry_out, nc);
    @(posedge sys_clk); #1;
    check("stored", mem_rdata, to_mem ? res : b);
    check("flag", carry_in, nc);
  endtask : do_op
  task automatic test_acc_ops;
    do_op(3'h0, 8'h81, 1'b1);
    do_op(3'h2, 8'h81, 1'b0);
    do_op(3'h2, 8'h7E, 1'b1);
    do_op(3'h4, 8'h01, 1'b1);
    $display("test_acc_ops done");
  endtask : test_acc_ops
  task automatic test_mem_ops;
    do_op(3'h1, 8'h81, 1'b0);
    do_op(3'h3, 8'h01, 1'b0);
    do_op(3'h5, 8'h01, 1'b0);
    do_op(3'h5, 8'h80, 1'b1);
    $display("test_mem_ops done");
  endtask : test_mem_ops
  task automatic test_unused;
    do_op(3'h6, 8'h5A, 1'b1);
    do_op(3'h7, 8'hA5, 1'b0);
    $display("test_unused done");
  endtask : test_unused
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    test_acc_ops();
    test_mem_ops();
    test_unused();
    final_report();
  end
endmodule : test_bru_rotate
